/* File: design/pwm_reload_period_deadtime.sv */
// Notes on behaviour
// - edge select 00 direct, 01 rising, 10 falling, 11 both edges.
// - with restart enabled and reload a not off, commutation raises reload and async qualifier.
// - reload a pulses once per control cycle when its source is time base a.
// - reloads b,c follow bases b,c; a is off at reset, selectable.
// - async qualifier matches reload a whenever commutation alone drives it.
// - commutation coinciding with normal reload keeps qualifier low.
// - period modulo a is a 15-bit count of pwm clocks.
// - modulo writes are buffered until load ok and next load cycle.
// - reading the modulo returns the buffered value.
// - deadtime a is a 12-bit pwm clock count for complementary use.
// - deadtime resets to 0xfff, 4095 pwm clocks.
// - after write protect is set, deadtime writes are ignored.
// - deadtime scales with the time base a prescaler.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pwm_reload_period_deadtime
  import pwm_reload_pkg::*;
#(
  parameter int pw = pwm_reload_pkg::period_w,
  parameter int dw = pwm_reload_pkg::deadtime_w
) (
  input wire logic clk_i, // core clock 50 mhz
  input wire logic reset_i, // sync reset, high
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic async_event_i, // commutation event input
  input wire logic reload_b_i, // time base b reload
  input wire logic reload_c_i, // time base c reload
  output logic reload_a_o, // reload event a
  output logic reload_b_o, // reload event b
  output logic reload_c_o, // reload event c
  output logic reload_async_qualifier_o, // reload a is async
  output logic [pw-1:0] period_active_o, // period in use by base a
  output logic pwm_hi_o, // complementary high side
  output logic pwm_lo_o // complementary low side
);
  import pwm_reload_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [pw-1:0] period_buf_r;
  logic [pw-1:0] period_act_r;
  logic [dw-1:0] deadtime_r;
  logic load_ok_a_r;
  logic global_load_ok_r;
  logic write_protect_r;
  logic restart_enable_r;
  logic [1:0] edge_sel_r;
  reload_src_t reload_a_sel_r;
  logic complementary_r;
  logic [prescale_w-1:0] prescale_r;
  logic ack_r;
  logic [31:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle per access
  // a write lands only at the edge after the wait cycle, where waitrequest is low, never earlier
  wire access = (avs_read || avs_write) && !ack_r;
  wire wr = avs_write && ack_r;
  wire hit_period = avs_address == addr_period_modulo_a;
  wire hit_dead = avs_address == addr_deadtime_a;
  wire hit_ctl = avs_address == addr_control;
  wire hit_stat = avs_address == addr_status;
  wire wr_period = wr && hit_period;
  wire wr_dead = wr && hit_dead && !write_protect_r;
  wire wr_ctl = wr && hit_ctl;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // time base a: prescaler and up counter
  logic [prescale_w-1:0] pre_cnt_r;
  logic [pw-1:0] cnt_r;
  wire pwm_tick = pre_cnt_r == prescale_r;
  wire cnt_wrap = pwm_tick && (cnt_r >= period_act_r - 1'b1);
  wire load_cycle = cnt_wrap;
  wire load_ok_any = load_ok_a_r || global_load_ok_r;
  wire gen_reload_a = load_cycle;
  wire pwm_raw = cnt_r < {1'b0, period_act_r[pw-1:1]};

  always_ff @(posedge clk_i)
  begin
    if (reset_i || pwm_tick)
      pre_cnt_r <= '0;
    else
      pre_cnt_r <= pre_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || cnt_wrap)
      cnt_r <= '0;
    else if (pwm_tick)
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      period_act_r <= period_reset;
    else if (load_cycle && load_ok_any)
      period_act_r <= period_buf_r;
  end
  assign period_active_o = period_act_r;

  ////////////////////////////////////////////////////////////////////////
  // commutation event edge select
  logic async_prev_r;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      async_prev_r <= 1'b0;
    else
      async_prev_r <= async_event_i;
  end
  wire rise = async_event_i && !async_prev_r;
  wire fall = !async_event_i && async_prev_r;
  logic async_evt;
  always_comb
  begin
    unique case (edge_sel_r)
      edge_direct: async_evt = async_event_i;
      edge_rising: async_evt = rise;
      edge_falling: async_evt = fall;
      edge_both: async_evt = rise || fall;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // reload outputs
  wire async_reload = restart_enable_r && async_evt;
  logic src_reload;
  always_comb
  begin
    unique case (reload_a_sel_r)
      src_off: src_reload = 1'b0;
      src_a: src_reload = gen_reload_a;
      src_b: src_reload = reload_b_i;
      src_c: src_reload = reload_c_i;
    endcase
  end
  wire async_to_a = async_reload && reload_a_sel_r != src_off;
  wire reload_a_nxt = src_reload || async_to_a;
  wire qual_nxt = async_to_a && !src_reload;
  logic reload_a_r;
  logic reload_b_r;
  logic reload_c_r;
  logic qual_r;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reload_a_r <= 1'b0;
      reload_b_r <= 1'b0;
      reload_c_r <= 1'b0;
      qual_r <= 1'b0;
    end
    else
    begin
      reload_a_r <= reload_a_nxt;
      reload_b_r <= reload_b_i;
      reload_c_r <= reload_c_i;
      qual_r <= qual_nxt;
    end
  end
  assign reload_a_o = reload_a_r;
  assign reload_b_o = reload_b_r;
  assign reload_c_o = reload_c_r;
  assign reload_async_qualifier_o = qual_r;

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      period_buf_r <= period_reset;
      deadtime_r <= deadtime_reset;
    end
    else
    begin
      if (wr_period && avs_byteenable[0])
        period_buf_r[7:0] <= avs_writedata[7:0];
      if (wr_period && avs_byteenable[1])
        period_buf_r[pw-1:8] <= avs_writedata[pw-1:8];
      if (wr_dead && avs_byteenable[0])
        deadtime_r[7:0] <= avs_writedata[7:0];
      if (wr_dead && avs_byteenable[1])
        deadtime_r[dw-1:8] <= avs_writedata[dw-1:8];
    end
  end

  // load-ok clears at the load cycle; a software set in that cycle wins
  wire set_ldok = wr_ctl && avs_byteenable[0];
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      load_ok_a_r <= 1'b0;
      global_load_ok_r <= 1'b0;
    end
    else
    begin
      if (set_ldok && avs_writedata[ctl_load_ok_a])
        load_ok_a_r <= 1'b1;
      else if (load_cycle)
        load_ok_a_r <= 1'b0;
      if (set_ldok && avs_writedata[ctl_global_load_ok])
        global_load_ok_r <= 1'b1;
      else if (load_cycle)
        global_load_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      write_protect_r <= 1'b0;
      restart_enable_r <= 1'b0;
      edge_sel_r <= edge_direct;
      reload_a_sel_r <= src_off;
      complementary_r <= 1'b0;
      prescale_r <= prescale_reset;
    end
    else if (wr_ctl)
    begin
      if (avs_byteenable[0])
      begin
        // write protect is sticky until reset
        write_protect_r <= write_protect_r || avs_writedata[ctl_write_protect];
        restart_enable_r <= avs_writedata[ctl_restart_enable];
        edge_sel_r <= avs_writedata[ctl_edge_sel_lo +: 2];
        reload_a_sel_r <= reload_src_t'(avs_writedata[ctl_reload_a_sel_lo +: 2]);
      end
      if (avs_byteenable[1])
        complementary_r <= avs_writedata[ctl_complementary];
      if (avs_byteenable[2])
        prescale_r <= avs_writedata[ctl_prescale_lo +: prescale_w];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads
  wire [31:0] ctl_word = {8'h00, prescale_r, 7'h00, complementary_r,
    reload_a_sel_r, edge_sel_r, restart_enable_r, write_protect_r,
    global_load_ok_r, load_ok_a_r};
  wire [31:0] stat_word = {{(32-pw){1'b0}}, period_act_r};
  wire [31:0] rd_mux =
    hit_period ? {{(32-pw){1'b0}}, period_buf_r} :
    hit_dead ? {{(32-dw){1'b0}}, deadtime_r} :
    hit_ctl ? ctl_word :
    hit_stat ? stat_word : unmapped_read;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      ack_r <= access;
      if (access && avs_read)
        rdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // complementary output pair with deadtime
  deadtime_gen #(
    .width(dw)
  ) u_dead (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(pwm_tick),
    .enable_i(complementary_r),
    .pwm_i(pwm_raw),
    .deadtime_i(deadtime_r),
    .out_hi_o(pwm_hi_o),
    .out_lo_o(pwm_lo_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_async_qual;
    @(posedge clk_i) disable iff (reset_i)
    async_to_a && !src_reload |=> reload_async_qualifier_o && reload_a_o;
  endproperty
  a_async_qual: assert property (p_async_qual)
    else $error("qualifier missing on async reload");

  property p_qual_implies_reload;
    @(posedge clk_i) disable iff (reset_i)
    reload_async_qualifier_o |-> reload_a_o;
  endproperty
  a_qual_implies_reload: assert property (p_qual_implies_reload)
    else $error("qualifier without reload a");

  property p_coincide;
    @(posedge clk_i) disable iff (reset_i)
    src_reload |=> !reload_async_qualifier_o;
  endproperty
  a_coincide: assert property (p_coincide)
    else $error("qualifier set on coincident reload");

  property p_restart;
    @(posedge clk_i) disable iff (reset_i)
    restart_enable_r && rise && edge_sel_r == edge_rising
      && reload_a_sel_r != src_off |=> reload_a_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("commutation did not reload");

  property p_off_quiet;
    @(posedge clk_i) disable iff (reset_i)
    reload_a_sel_r == src_off |=> !reload_a_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("reload a active while off");

  property p_reload_b;
    @(posedge clk_i) disable iff (reset_i)
    reload_b_i |=> reload_b_o;
  endproperty
  a_reload_b: assert property (p_reload_b)
    else $error("reload b not followed");

  property p_wp;
    @(posedge clk_i) disable iff (reset_i)
    write_protect_r && avs_write |=> $stable(deadtime_r);
  endproperty
  a_wp: assert property (p_wp)
    else $error("deadtime written while protected");

  property p_buffered;
    @(posedge clk_i) disable iff (reset_i)
    !(load_cycle && load_ok_any) |=> $stable(period_act_r);
  endproperty
  a_buffered: assert property (p_buffered)
    else $error("period changed outside load cycle");

  sequence s_rd_period;
    avs_read && hit_period && !ack_r ##1 avs_read;
  endsequence
  property p_read_buf;
    @(posedge clk_i) disable iff (reset_i)
    s_rd_period |-> avs_readdata[pw-1:0] == $past(period_buf_r);
  endproperty
  a_read_buf: assert property (p_read_buf)
    else $error("period read not buffered value");
endmodule : pwm_reload_period_deadtime
`default_nettype wire

/* File: include/pwm_reload_pkg.sv */
package pwm_reload_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] addr_period_modulo_a = 4'h0;
  localparam logic [3:0] addr_deadtime_a = 4'h4;
  localparam logic [3:0] addr_control = 4'h8;
  localparam logic [3:0] addr_status = 4'hc;
  // field widths and positions
  localparam int period_w = 15;
  localparam int deadtime_w = 12;
  localparam int prescale_w = 8;
  localparam int ctl_load_ok_a = 0;
  localparam int ctl_global_load_ok = 1;
  localparam int ctl_write_protect = 2;
  localparam int ctl_restart_enable = 3;
  localparam int ctl_edge_sel_lo = 4;
  localparam int ctl_reload_a_sel_lo = 6;
  localparam int ctl_complementary = 8;
  localparam int ctl_prescale_lo = 16;
  // reset values
  localparam logic [11:0] deadtime_reset = 12'hfff;
  localparam logic [14:0] period_reset = 15'h7fff;
  localparam logic [7:0] prescale_reset = 8'h00;
  // edge select encodings
  localparam logic [1:0] edge_direct = 2'h0;
  localparam logic [1:0] edge_rising = 2'h1;
  localparam logic [1:0] edge_falling = 2'h2;
  localparam logic [1:0] edge_both = 2'h3;
  // reload output a source
  typedef enum logic [1:0] {src_off, src_a, src_b, src_c} reload_src_t;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;
endpackage : pwm_reload_pkg

/* File: design/deadtime_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module deadtime_gen #(
  parameter int width = 12
) (
  input wire logic clk_i, // core clock
  input wire logic reset_i, // sync reset, high
  input wire logic tick_i, // pwm clock enable
  input wire logic enable_i, // complementary mode
  input wire logic pwm_i, // raw pwm level
  input wire logic [width-1:0] deadtime_i, // deadtime count
  output logic out_hi_o, // high side output
  output logic out_lo_o // low side output
);
  logic prev_r;
  logic [width-1:0] cnt_r;
  logic hi_r;
  logic lo_r;
  wire changed = pwm_i != prev_r;
  wire counting = cnt_r != '0;
  assign out_hi_o = hi_r;
  assign out_lo_o = lo_r;
  // turn-off is immediate, turn-on waits out the count
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      prev_r <= 1'b0;
      cnt_r <= '0;
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end
    else if (!enable_i)
    begin
      prev_r <= pwm_i;
      cnt_r <= '0;
      hi_r <= pwm_i;
      lo_r <= 1'b0;
    end
    else
    begin
      prev_r <= pwm_i;
      if (changed)
      begin
        hi_r <= 1'b0;
        lo_r <= 1'b0;
        cnt_r <= deadtime_i;
        if (deadtime_i == '0)
        begin
          hi_r <= pwm_i;
          lo_r <= !pwm_i;
        end
      end
      else if (counting && tick_i)
      begin
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == {{(width-1){1'b0}}, 1'b1})
        begin
          hi_r <= prev_r;
          lo_r <= !prev_r;
        end
      end
    end
  end
endmodule : deadtime_gen
`default_nettype wire

/* File: verification/reload_consumer.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side logic that counts the reload events it is handed
module reload_consumer (
  input wire logic clk_i, // core clock
  input wire logic reset_i, // sync reset, high
  input wire logic reload_a_i, // reload event a
  input wire logic reload_b_i, // reload event b
  input wire logic reload_c_i, // reload event c
  input wire logic qual_i, // async qualifier
  output logic [15:0] cnt_a_o, // cycles with a high
  output logic [15:0] cnt_b_o, // cycles with b high
  output logic [15:0] cnt_c_o, // cycles with c high
  output logic [15:0] cnt_q_o, // cycles with qualifier high
  output logic [15:0] cnt_bad_o // qualifier without reload a
);
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_a_o <= 16'h0;
      cnt_b_o <= 16'h0;
      cnt_c_o <= 16'h0;
      cnt_q_o <= 16'h0;
      cnt_bad_o <= 16'h0;
    end
    else
    begin
      cnt_a_o <= cnt_a_o + 16'(reload_a_i);
      cnt_b_o <= cnt_b_o + 16'(reload_b_i);
      cnt_c_o <= cnt_c_o + 16'(reload_c_i);
      cnt_q_o <= cnt_q_o + 16'(qual_i);
      cnt_bad_o <= cnt_bad_o + 16'(qual_i & ~reload_a_i);
    end
  end
endmodule : reload_consumer
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pwm_reload_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic async_ev = 1'b0;
  logic rb = 1'b0;
  logic rc = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic waitreq, ra_o, rb_o, rc_o, qual, hi, lo;
  logic [14:0] pact;
  logic [15:0] ca, cb, cc, cq, cbad, sa, sb, sc, sq;
  int failures = 0;
  int checks = 0;
  int p, dt, n;
  int nh = 0;
  int nl = 0;
  int sh, sl;

  always #10 clk_i = ~clk_i;

  pwm_reload_period_deadtime i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .async_event_i(async_ev), .reload_b_i(rb),
    .reload_c_i(rc), .reload_a_o(ra_o), .reload_b_o(rb_o),
    .reload_c_o(rc_o), .reload_async_qualifier_o(qual),
    .period_active_o(pact), .pwm_hi_o(hi), .pwm_lo_o(lo));

  reload_consumer i_sink (.clk_i(clk_i), .reset_i(reset_i),
    .reload_a_i(ra_o), .reload_b_i(rb_o), .reload_c_i(rc_o),
    .qual_i(qual), .cnt_a_o(ca), .cnt_b_o(cb), .cnt_c_o(cc),
    .cnt_q_o(cq), .cnt_bad_o(cbad));

  //////////////////////////////////////////////////////////////////////
  task stop_test;
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one avalon access; q holds read data taken at the answering edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    chk("waitrequest", 32'h0, {31'h0, waitreq});
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  function automatic logic [31:0] ctl(input logic ld, input logic rs,
    input logic [1:0] ed, input logic [1:0] sr, input logic cm);
    return {23'h0, cm, sr, ed, rs, 2'b00, ld};
  endfunction : ctl

  // cycles a side is on over ten periods of a phase len with deadtime d
  function automatic int dead_on(input int len, input int d);
    return (len > d) ? 10 * (len - d) : 0;
  endfunction : dead_on

  function automatic int hits(input logic [1:0] m, input logic rs);
    if (!rs)
      return 0;
    return (m == edge_both) ? 2 : 1;
  endfunction : hits

  task pulse(input logic a, input logic b, input logic c);
    @(posedge clk_i);
    async_ev <= a;
    rb <= b;
    rc <= c;
    @(posedge clk_i);
    async_ev <= 1'b0;
    rb <= 1'b0;
    rc <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pulse

  //////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
    if (reset_i === 1'b0)
    begin
      if (hi === 1'b1 && lo === 1'b1)
      begin
        failures++;
        $display("CHECK FAILED pwm pair expected one side seen both");
      end
      if (hi === 1'b1)
        nh <= nh + 1;
      if (lo === 1'b1)
        nl <= nl + 1;
    end

  initial
  begin
    #(20 * 90000);
    failures++;
    $display("CHECK FAILED watchdog expected done seen hang");
    stop_test();
  end

  initial
  begin
    void'($urandom(32'hc996cd9a));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(1'b0, addr_deadtime_a, 32'h0);
    chk("deadtime reset", {20'h0, deadtime_reset}, q);
    chk("active period reset", {17'h0, period_reset}, {17'h0, pact});
    bus(1'b0, 4'h1, 32'h0);
    chk("unmapped read", unmapped_read, q);
    sa = ca;
    sb = cb;
    sc = cc;
    pulse(1'b0, 1'b1, 1'b1);
    chk("reload a off", 32'h0, 32'(ca - sa));
    chk("reload b", 32'h1, 32'(cb - sb));
    chk("reload c", 32'h1, 32'(cc - sc));
    for (int s = 2; s < 4; s++)
    begin
      bus(1'b1, addr_control, ctl(1'b0, 1'b0, edge_direct, 2'(s), 1'b0));
      sa = ca;
      pulse(1'b0, s == 2, s == 3);
      chk("reload a source", 32'h1, 32'(ca - sa));
    end
    p = 2 + ($urandom % 200);
    bus(1'b1, addr_period_modulo_a, 32'(p));
    bus(1'b0, addr_period_modulo_a, 32'h0);
    chk("period buffer", 32'(p), q);
    repeat (20) @(posedge clk_i);
    chk("period held", {17'h0, period_reset}, {17'h0, pact});
    bus(1'b1, addr_control, ctl(1'b1, 1'b0, edge_direct, src_off, 1'b0));
    n = 0;
    while (pact !== p[14:0] && n < 40000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("period loaded", 32'(p), {17'h0, pact});
    bus(1'b0, addr_status, 32'h0);
    chk("status period", 32'(p), q);
    dt = $urandom % 4096;
    bus(1'b1, addr_deadtime_a, 32'(dt));
    bus(1'b0, addr_deadtime_a, 32'h0);
    chk("deadtime rw", 32'(dt), q);
    dt = $urandom % (p / 2 + 1);
    bus(1'b1, addr_deadtime_a, 32'(dt));
    bus(1'b1, addr_control, ctl(1'b0, 1'b0, edge_direct, src_a, 1'b1));
    repeat (2 * p) @(posedge clk_i);
    sa = ca;
    sh = nh;
    sl = nl;
    repeat (10 * p) @(posedge clk_i);
    chk("reload a per cycle", 32'd10, 32'(ca - sa));
    chk("high side on", 32'(dead_on(p / 2, dt)), 32'(nh - sh));
    chk("low side on", 32'(dead_on(p - p / 2, dt)), 32'(nl - sl));
    bus(1'b1, addr_control,
      ctl(1'b0, 1'b0, edge_direct, src_a, 1'b0) | 32'h0001_0000);
    repeat (2 * p) @(posedge clk_i);
    sa = ca;
    repeat (20 * p) @(posedge clk_i);
    chk("reload a prescaled", 32'd10, 32'(ca - sa));
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b1, addr_control, ctl(1'b0, k < 4, 2'(k), src_b, 1'b0));
      sa = ca;
      sq = cq;
      pulse(1'b1, 1'b0, 1'b0);
      chk("async reload", 32'(hits(2'(k), k < 4)), 32'(ca - sa));
      chk("async qualifier", 32'(hits(2'(k), k < 4)), 32'(cq - sq));
    end
    chk("qualifier alone", 32'h0, {16'h0, cbad});
    bus(1'b1, addr_control, ctl(1'b0, 1'b1, edge_direct, src_b, 1'b0));
    @(posedge clk_i);
    async_ev <= 1'b1;
    rb <= 1'b1;
    @(posedge clk_i);
    async_ev <= 1'b0;
    rb <= 1'b0;
    @(posedge clk_i);
    chk("coincident reload", 32'h1, {31'h0, ra_o});
    chk("coincident qualifier", 32'h0, {31'h0, qual});
    bus(1'b1, addr_control, 32'h4);
    bus(1'b1, addr_deadtime_a, 32'(dt ^ 32'hfff));
    bus(1'b0, addr_deadtime_a, 32'h0);
    chk("deadtime protected", 32'(dt), q);
    stop_test();
  end
endmodule : tb
`default_nettype wire
